// File: common/sbc_pkg.sv
// Purpose: constants and types shared by the operating-mode sequencer
// Assumes: 20 MHz system clock
// Notes:   times kept in their printed unit, cycle counts derived from them

package sbc_pkg;

  // ****************************************************************
  // clock
  // ****************************************************************
  localparam int CLK_MHZ = 20;

  // ****************************************************************
  // times in printed units
  // ****************************************************************
  localparam int T_SYNCH_US      = 15;
  localparam int T_MODSEL_US     = 30;
  localparam int T_UV_FILTER_US  = 25;
  localparam int T_WAKE_US       = 80;
  localparam int T_RESET_EXT_MS  = 5;
  localparam int T_DOM_TIMEOUT_MS = 13;

  // ****************************************************************
  // cycle counts
  // ****************************************************************
  localparam logic [8:0]  SYNC_CYC   = 9'(T_SYNCH_US * CLK_MHZ);
  localparam logic [16:0] MODSEL_CYC = 17'(T_MODSEL_US * CLK_MHZ);
  localparam logic [8:0]  UV_CYC     = 9'(T_UV_FILTER_US * CLK_MHZ);
  localparam logic [10:0] WAKE_CYC   = 11'(T_WAKE_US * CLK_MHZ);
  localparam int          RESET_CYC_DEF = T_RESET_EXT_MS * 1000 * CLK_MHZ;
  localparam int          TXTO_CYC_DEF  = T_DOM_TIMEOUT_MS * 1000 * CLK_MHZ;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic RXD_IDLE      = 1'b1;
  localparam logic TX_IDLE       = 1'b1;

  // ****************************************************************
  // modes
  // ****************************************************************
  typedef enum logic [2:0] {
    SBC_SHUTDOWN,
    SBC_RESET,
    SBC_NORMAL,
    SBC_STANDBY,
    SBC_SLEEP,
    SBC_THERMAL
  } sbc_mode_e;

  typedef enum logic [1:0] {
    SBC_XCVR_OFF,
    SBC_XCVR_ACTIVE,
    SBC_XCVR_WAKEUP
  } sbc_xcvr_e;

endpackage

// File: rtl/sbc_operating_mode_control.sv
// Purpose: operating-mode sequencer of a supply and bus-transceiver companion chip
// Assumes: all analog levels arrive as digital comparator flags from other domains
// Notes:   one packed state struct, one always_comb, one always_ff
//
// Behaviour
// - supply below low level forces Shutdown asynchronously
// - Shutdown exits to Reset on supply high, cool
// - Shutdown: regulator off, rxd high, reset low
// - Reset entered on exits, undervoltage, sleep wakeups
// - Reset: regulator on, reset low, rxd shows wakeup
// - Reset ends after extension; enable picks mode
// - undervoltage filtered before acting
// - enable high in Standby requests Normal
// - Normal: transceiver active, regulator on, reset high
// - enable low then transmit high gives Standby
// - enable low then transmit low gives Sleep
// - asynchronous inputs get synchronization delay
// - mode selection delay before sampling transmit
// - state changes bounded delay after pin change
// - Standby: wakeup transceiver, rxd latched after wakeup
// - Sleep: regulator off, wakeup or enable to Reset
// - hot die enters Thermal Shutdown, regulator off
// - Thermal Shutdown left only when cooled
// - dominant only after transmit falling edge
// - enable falling in Normal stops transmitter
// - wakeup mode: receiver on, rxd low latched
// - dominant bus held long enough is a wakeup
// - wakeup begun in Active still counts
// - Off mode: transceiver dead, rxd high
// - dominant timeout stops long transmit low

`timescale 1ns/1ps

module sbc_operating_mode_control #(
  parameter int RESET_CYC = sbc_pkg::RESET_CYC_DEF,
  parameter int TXTO_CYC  = sbc_pkg::TXTO_CYC_DEF
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // supply and die monitors
  input  wire logic  supply_above_por_low_level,
  input  wire logic  supply_above_por_high_level,
  input  wire logic  regulator_undervoltage_level,
  input  wire logic  thermal_shutdown_level,
  // host pins
  input  wire logic  enable,
  input  wire logic  txd,
  input  wire logic  dominant_timeout_enable,
  // bus receiver
  input  wire logic  bus_dominant,
  // outputs
  output logic       system_reset_out_n,
  output logic       rxd,
  output logic       regulator_on,
  output logic       lin_drive_dominant,
  output logic [1:0] xcvr_mode
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    sbc_pkg::sbc_mode_e mode;
    sbc_pkg::sbc_xcvr_e xcvr;
    logic [1:0]         en_sy;
    logic [1:0]         tx_sy;
    logic [1:0]         porh_sy;
    logic [1:0]         uv_sy;
    logic [1:0]         th_sy;
    logic [1:0]         bus_sy;
    logic [1:0]         dto_sy;
    logic               en_f;
    logic [8:0]         en_tmr;
    logic               tx_prev;
    logic               uv_f;
    logic [8:0]         uv_tmr;
    logic [16:0]        mode_tmr;
    logic [10:0]        wake_tmr;
    logic               wake_pend;
    logic [17:0]        txto_tmr;
    logic               rst_out_n;
    logic               rxd;
    logic               reg_on;
    logic               lin_dom;
  } sbc_state_s;

  sbc_state_s st;
  sbc_state_s next_st;
  logic       arst_n;
  logic       wake_ev;
  logic       dom_timeout;

  // supply loss acts as asynchronous reset into Shutdown
  assign arst_n = rst_n & supply_above_por_low_level;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    wake_ev = 1'b0;
    dom_timeout = 1'b0;

    // two-flop synchronizers
    next_st.en_sy   = {st.en_sy[0], enable};
    next_st.tx_sy   = {st.tx_sy[0], txd};
    next_st.porh_sy = {st.porh_sy[0], supply_above_por_high_level};
    next_st.uv_sy   = {st.uv_sy[0], regulator_undervoltage_level};
    next_st.th_sy   = {st.th_sy[0], thermal_shutdown_level};
    next_st.bus_sy  = {st.bus_sy[0], bus_dominant};
    next_st.dto_sy  = {st.dto_sy[0], dominant_timeout_enable};
    next_st.tx_prev = st.tx_sy[1];

    // enable takes effect only after stable for the sync delay
    if (st.en_sy[1] == st.en_f) begin
      next_st.en_tmr = '0;
    end else if (st.en_tmr == sbc_pkg::SYNC_CYC - 9'd1) begin
      next_st.en_f   = st.en_sy[1];
      next_st.en_tmr = '0;
    end else begin
      next_st.en_tmr = st.en_tmr + 9'd1;
    end

    // undervoltage filter
    if (st.uv_sy[1] == st.uv_f) begin
      next_st.uv_tmr = '0;
    end else if (st.uv_tmr == sbc_pkg::UV_CYC - 9'd1) begin
      next_st.uv_f   = st.uv_sy[1];
      next_st.uv_tmr = '0;
    end else begin
      next_st.uv_tmr = st.uv_tmr + 9'd1;
    end

    // wakeup detector; count survives the Active to Wakeup switch
    if (st.bus_sy[1] && st.xcvr != sbc_pkg::SBC_XCVR_OFF) begin
      if (st.wake_tmr == sbc_pkg::WAKE_CYC - 11'd1) begin
        wake_ev = (st.xcvr == sbc_pkg::SBC_XCVR_WAKEUP);
      end else begin
        next_st.wake_tmr = st.wake_tmr + 11'd1;
      end
    end else begin
      next_st.wake_tmr = '0;
    end

    // mode sequencing
    unique case (st.mode)
      sbc_pkg::SBC_SHUTDOWN: begin
        if (st.porh_sy[1] && !st.th_sy[1]) begin
          next_st.mode = sbc_pkg::SBC_RESET;
        end
      end
      sbc_pkg::SBC_RESET: begin
        if (st.th_sy[1]) begin
          next_st.mode = sbc_pkg::SBC_THERMAL;
        end else if (st.uv_f) begin
          next_st.mode_tmr = '0;
        end else if (st.mode_tmr == 17'(RESET_CYC - 1)) begin
          next_st.mode = st.en_f ? sbc_pkg::SBC_NORMAL : sbc_pkg::SBC_STANDBY;
        end else begin
          next_st.mode_tmr = st.mode_tmr + 17'd1;
        end
      end
      sbc_pkg::SBC_NORMAL: begin
        if (st.th_sy[1]) begin
          next_st.mode = sbc_pkg::SBC_THERMAL;
        end else if (st.uv_f) begin
          next_st.mode = sbc_pkg::SBC_RESET;
        end else if (!st.en_f) begin
          if (st.mode_tmr == sbc_pkg::MODSEL_CYC - 17'd1) begin
            next_st.mode = st.tx_sy[1] ? sbc_pkg::SBC_STANDBY : sbc_pkg::SBC_SLEEP;
          end else begin
            next_st.mode_tmr = st.mode_tmr + 17'd1;
          end
        end else begin
          next_st.mode_tmr = '0;
        end
      end
      sbc_pkg::SBC_STANDBY: begin
        if (st.th_sy[1]) begin
          next_st.mode = sbc_pkg::SBC_THERMAL;
        end else if (st.uv_f) begin
          next_st.mode = sbc_pkg::SBC_RESET;
        end else if (st.en_f) begin
          next_st.mode = sbc_pkg::SBC_NORMAL;
        end
      end
      sbc_pkg::SBC_SLEEP: begin
        if (st.th_sy[1]) begin
          next_st.mode = sbc_pkg::SBC_THERMAL;
        end else if (wake_ev || st.en_f) begin
          next_st.mode = sbc_pkg::SBC_RESET;
        end
      end
      sbc_pkg::SBC_THERMAL: begin
        if (!st.th_sy[1]) begin
          next_st.mode = sbc_pkg::SBC_RESET;
        end
      end
      default: begin
        next_st.mode = sbc_pkg::SBC_SHUTDOWN;
      end
    endcase

    if (next_st.mode != st.mode) begin
      next_st.mode_tmr = '0;
    end

    // wakeup latch; a new wakeup wins over the clear
    next_st.wake_pend = wake_ev || (st.wake_pend && !next_st.en_f &&
                        next_st.mode != sbc_pkg::SBC_SHUTDOWN);

    // mode outputs
    unique case (next_st.mode)
      sbc_pkg::SBC_SHUTDOWN: begin
        next_st.xcvr      = sbc_pkg::SBC_XCVR_OFF;
        next_st.rst_out_n = 1'b0;
        next_st.reg_on    = 1'b0;
        next_st.rxd       = sbc_pkg::RXD_IDLE;
      end
      sbc_pkg::SBC_RESET: begin
        next_st.xcvr      = sbc_pkg::SBC_XCVR_WAKEUP;
        next_st.rst_out_n = 1'b0;
        next_st.reg_on    = 1'b1;
        next_st.rxd       = !next_st.wake_pend;
      end
      sbc_pkg::SBC_NORMAL: begin
        next_st.xcvr      = sbc_pkg::SBC_XCVR_ACTIVE;
        next_st.rst_out_n = 1'b1;
        next_st.reg_on    = 1'b1;
        next_st.rxd       = !st.bus_sy[1];
      end
      sbc_pkg::SBC_STANDBY: begin
        next_st.xcvr      = sbc_pkg::SBC_XCVR_WAKEUP;
        next_st.rst_out_n = 1'b1;
        next_st.reg_on    = 1'b1;
        next_st.rxd       = !next_st.wake_pend;
      end
      sbc_pkg::SBC_SLEEP: begin
        next_st.xcvr      = sbc_pkg::SBC_XCVR_WAKEUP;
        next_st.rst_out_n = 1'b1;
        next_st.reg_on    = 1'b0;
        next_st.rxd       = !next_st.wake_pend;
      end
      sbc_pkg::SBC_THERMAL: begin
        next_st.xcvr      = sbc_pkg::SBC_XCVR_WAKEUP;
        next_st.rst_out_n = 1'b0;
        next_st.reg_on    = 1'b0;
        next_st.rxd       = !next_st.wake_pend;
      end
      default: begin
        next_st.xcvr      = sbc_pkg::SBC_XCVR_OFF;
        next_st.rst_out_n = 1'b0;
        next_st.reg_on    = 1'b0;
        next_st.rxd       = sbc_pkg::RXD_IDLE;
      end
    endcase

    // transmitter with dominant timeout
    dom_timeout = st.dto_sy[1] && (st.txto_tmr == 18'(TXTO_CYC - 1));
    if (st.lin_dom && !st.tx_sy[1] && !dom_timeout) begin
      next_st.txto_tmr = st.txto_tmr + 18'd1;
    end else if (!st.tx_sy[1] && dom_timeout) begin
      next_st.txto_tmr = st.txto_tmr;
    end else begin
      next_st.txto_tmr = '0;
    end
    if (next_st.mode == sbc_pkg::SBC_NORMAL && st.mode == sbc_pkg::SBC_NORMAL &&
        next_st.en_f && st.en_sy[1] && !st.tx_sy[1] && !dom_timeout) begin
      next_st.lin_dom = st.lin_dom || st.tx_prev;
    end else begin
      next_st.lin_dom = 1'b0;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st         <= '0;
      st.rxd     <= sbc_pkg::RXD_IDLE;
      st.tx_prev <= sbc_pkg::TX_IDLE;
      st.tx_sy   <= {2{sbc_pkg::TX_IDLE}};
    end else begin
      st <= next_st;
    end
  end

  assign system_reset_out_n = st.rst_out_n;
  assign rxd                = st.rxd;
  assign regulator_on       = st.reg_on;
  assign lin_drive_dominant = st.lin_dom;
  assign xcvr_mode          = st.xcvr;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_shutdown_out;
    st.mode == sbc_pkg::SBC_SHUTDOWN |-> !system_reset_out_n && !regulator_on && rxd &&
      xcvr_mode == sbc_pkg::SBC_XCVR_OFF && !lin_drive_dominant;
  endproperty
  a_shutdown_out: assert property (p_shutdown_out) else $error("shutdown outputs wrong");

  property p_shutdown_exit;
    $past(st.mode) == sbc_pkg::SBC_SHUTDOWN && st.mode != sbc_pkg::SBC_SHUTDOWN |->
      st.mode == sbc_pkg::SBC_RESET && !$past(st.th_sy[1]) && $past(st.porh_sy[1]);
  endproperty
  a_shutdown_exit: assert property (p_shutdown_exit) else $error("bad shutdown exit");

  property p_reset_out;
    st.mode == sbc_pkg::SBC_RESET |-> !system_reset_out_n && regulator_on &&
      rxd == !st.wake_pend;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset mode outputs wrong");

  property p_reset_exit;
    $past(st.mode) == sbc_pkg::SBC_RESET &&
      (st.mode == sbc_pkg::SBC_NORMAL || st.mode == sbc_pkg::SBC_STANDBY) |->
      $past(st.mode_tmr) == 17'(RESET_CYC - 1) && (st.mode == sbc_pkg::SBC_NORMAL) == $past(st.en_f);
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("reset left early");

  property p_uv_filter;
    $rose(st.uv_f) |-> $past(st.uv_tmr) == sbc_pkg::UV_CYC - 9'd1 && $past(st.uv_sy[1]);
  endproperty
  a_uv_filter: assert property (p_uv_filter) else $error("undervoltage not filtered");

  property p_normal_out;
    st.mode == sbc_pkg::SBC_NORMAL |-> system_reset_out_n && regulator_on &&
      xcvr_mode == sbc_pkg::SBC_XCVR_ACTIVE;
  endproperty
  a_normal_out: assert property (p_normal_out) else $error("normal outputs wrong");

  property p_lowpower_select;
    $past(st.mode) == sbc_pkg::SBC_NORMAL &&
      (st.mode == sbc_pkg::SBC_STANDBY || st.mode == sbc_pkg::SBC_SLEEP) |->
      $past(st.mode_tmr) == sbc_pkg::MODSEL_CYC - 17'd1 &&
      (st.mode == sbc_pkg::SBC_STANDBY) == $past(st.tx_sy[1]);
  endproperty
  a_lowpower_select: assert property (p_lowpower_select) else $error("bad low power selection");

  property p_en_sync;
    $changed(st.en_f) |-> $past(st.en_tmr) == sbc_pkg::SYNC_CYC - 9'd1;
  endproperty
  a_en_sync: assert property (p_en_sync) else $error("enable taken without sync delay");

  property p_standby_out;
    st.mode == sbc_pkg::SBC_STANDBY |-> system_reset_out_n && regulator_on &&
      xcvr_mode == sbc_pkg::SBC_XCVR_WAKEUP && rxd == !st.wake_pend;
  endproperty
  a_standby_out: assert property (p_standby_out) else $error("standby outputs wrong");

  property p_sleep_out;
    st.mode == sbc_pkg::SBC_SLEEP |-> !regulator_on && xcvr_mode == sbc_pkg::SBC_XCVR_WAKEUP;
  endproperty
  a_sleep_out: assert property (p_sleep_out) else $error("sleep outputs wrong");

  property p_thermal_out;
    st.mode == sbc_pkg::SBC_THERMAL |-> !regulator_on && !system_reset_out_n &&
      xcvr_mode == sbc_pkg::SBC_XCVR_WAKEUP;
  endproperty
  a_thermal_out: assert property (p_thermal_out) else $error("thermal outputs wrong");

  property p_dom_edge;
    $rose(lin_drive_dominant) |-> $past(st.tx_prev) && !$past(st.tx_sy[1]);
  endproperty
  a_dom_edge: assert property (p_dom_edge) else $error("dominant without falling edge");

  property p_dom_en;
    !st.en_f |-> !lin_drive_dominant;
  endproperty
  a_dom_en: assert property (p_dom_en) else $error("transmitter on with enable low");

  property p_dom_cut;
    !st.en_sy[1] |=> !lin_drive_dominant;
  endproperty
  a_dom_cut: assert property (p_dom_cut) else $error("transmitter not cut on enable fall");

  property p_wake_time;
    $rose(st.wake_pend) |-> $past(st.wake_tmr) == sbc_pkg::WAKE_CYC - 11'd1 && $past(st.bus_sy[1]);
  endproperty
  a_wake_time: assert property (p_wake_time) else $error("wakeup too short");

  property p_dom_timeout;
    lin_drive_dominant && st.dto_sy[1] |-> st.txto_tmr <= 18'(TXTO_CYC - 1);
  endproperty
  a_dom_timeout: assert property (p_dom_timeout) else $error("dominant timeout missed");

endmodule

// File: bench/sbc_host_model.sv
// Purpose: host controller model driving the enable and transmit pins
// Assumes: pins change only at the falling clock edge
// Notes:   the caller holds the pins through the selection window

`timescale 1ns/1ps

module sbc_host_model (
  // clock
  input  wire logic clk,
  // host pins
  output logic      enable,
  output logic      txd
);
  // ****************************************************************
  // pin drivers
  // ****************************************************************
  initial begin
    enable = 1'b0;
    txd    = 1'b1;
  end

  task automatic set_pins(input logic en, input logic tx);
    @(negedge clk);
    txd    = tx;
    enable = en;
  endtask

  // enable high asks for normal operation
  task automatic ask_normal();
    set_pins(1'b1, txd);
  endtask

  // enable low with transmit held high asks for standby
  task automatic ask_standby();
    set_pins(1'b0, 1'b1);
  endtask

  // enable low with transmit held low asks for sleep
  task automatic ask_sleep();
    set_pins(1'b0, 1'b0);
  endtask

  task automatic drive_tx(input logic tx);
    set_pins(enable, tx);
  endtask
endmodule

// File: bench/sbc_operating_mode_control_tb_top.sv
// Purpose: self-checking bench of the operating-mode sequencer
// Assumes: shortened reset extension and dominant timeout counts
// Notes:   waits follow the fixed latencies of the sequencer

`timescale 1ns/1ps

`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end

module sbc_operating_mode_control_tb_top;
  localparam int         RST_EXT = 40;
  localparam int         TX_TO   = 50;
  localparam logic [1:0] M_OFF   = 2'(sbc_pkg::SBC_XCVR_OFF);
  localparam logic [1:0] M_ACT   = 2'(sbc_pkg::SBC_XCVR_ACTIVE);
  localparam logic [1:0] M_WAKE  = 2'(sbc_pkg::SBC_XCVR_WAKEUP);

  logic       clk;
  logic       rst_n;
  logic       sup_lo;
  logic       sup_hi;
  logic       uv;
  logic       hot;
  logic       dto;
  logic       bus_dom;
  logic       enable;
  logic       txd;
  logic       rst_out_n;
  logic       rxd;
  logic       reg_on;
  logic       drv_dom;
  logic [1:0] xmode;
  int         fail_count;
  int         samples_checked;

  // ****************************************************************
  // instances
  // ****************************************************************
  sbc_operating_mode_control #(.RESET_CYC(RST_EXT), .TXTO_CYC(TX_TO)) DUT (
    .clk                          (clk),
    .rst_n                        (rst_n),
    .supply_above_por_low_level   (sup_lo),
    .supply_above_por_high_level  (sup_hi),
    .regulator_undervoltage_level (uv),
    .thermal_shutdown_level       (hot),
    .enable                       (enable),
    .txd                          (txd),
    .dominant_timeout_enable      (dto),
    .bus_dominant                 (bus_dom),
    .system_reset_out_n           (rst_out_n),
    .rxd                          (rxd),
    .regulator_on                 (reg_on),
    .lin_drive_dominant           (drv_dom),
    .xcvr_mode                    (xmode)
  );

  sbc_host_model host (
    .clk    (clk),
    .enable (enable),
    .txd    (txd)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic state_is(input logic [1:0] m, input logic ro, input logic rg);
    `CHK("transceiver mode", m, xmode)
    `CHK("system reset out", ro, rst_out_n)
    `CHK("regulator on", rg, reg_on)
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_startup();
    state_is(M_OFF, 1'b0, 1'b0);
    `CHK("rxd", 1'b1, rxd)
    rst_n = 1'b1;
    cyc(10);
    state_is(M_WAKE, 1'b0, 1'b1);
    cyc(50);
    state_is(M_WAKE, 1'b1, 1'b1);
    bus_dom = 1'b1;
    cyc(500);
    bus_dom = 1'b0;
    cyc(5);
    `CHK("rxd", 1'b1, rxd)
  endtask

  task automatic t_normal();
    host.drive_tx(1'b0);
    host.ask_normal();
    cyc(295);
    `CHK("transceiver mode", M_WAKE, xmode)
    cyc(15);
    state_is(M_ACT, 1'b1, 1'b1);
    `CHK("drive dominant", 1'b0, drv_dom)
  endtask

  task automatic t_transmit();
    dto = 1'b1;
    host.drive_tx(1'b1);
    cyc(5);
    host.drive_tx(1'b0);
    cyc(1);
    `CHK("drive dominant", 1'b0, drv_dom)
    cyc(4);
    `CHK("drive dominant", 1'b1, drv_dom)
    cyc(40);
    `CHK("drive dominant", 1'b1, drv_dom)
    cyc(15);
    `CHK("drive dominant", 1'b0, drv_dom)
    dto = 1'b0;
    host.drive_tx(1'b1);
    cyc(5);
    host.drive_tx(1'b0);
    cyc(5);
    `CHK("drive dominant", 1'b1, drv_dom)
  endtask

  task automatic t_sleep();
    host.ask_sleep();
    cyc(5);
    `CHK("drive dominant", 1'b0, drv_dom)
    cyc(305);
    `CHK("drive dominant", 1'b0, drv_dom)
    cyc(570);
    `CHK("transceiver mode", M_ACT, xmode)
    cyc(40);
    state_is(M_WAKE, 1'b1, 1'b0);
  endtask

  task automatic t_wake();
    bus_dom = 1'b1;
    cyc(1590);
    `CHK("regulator on", 1'b0, reg_on)
    cyc(25);
    state_is(M_WAKE, 1'b0, 1'b1);
    `CHK("rxd", 1'b0, rxd)
    bus_dom = 1'b0;
    host.ask_standby();
    cyc(50);
    state_is(M_WAKE, 1'b1, 1'b1);
    `CHK("rxd", 1'b0, rxd)
    host.ask_normal();
    cyc(310);
    state_is(M_ACT, 1'b1, 1'b1);
    `CHK("rxd", 1'b1, rxd)
  endtask

  task automatic t_undervoltage();
    uv = 1'b1;
    cyc(400);
    uv = 1'b0;
    cyc(10);
    `CHK("system reset out", 1'b1, rst_out_n)
    uv = 1'b1;
    cyc(495);
    `CHK("system reset out", 1'b1, rst_out_n)
    cyc(20);
    state_is(M_WAKE, 1'b0, 1'b1);
    uv = 1'b0;
    cyc(600);
    state_is(M_ACT, 1'b1, 1'b1);
  endtask

  task automatic t_thermal();
    hot = 1'b1;
    cyc(5);
    state_is(M_WAKE, 1'b0, 1'b0);
    cyc(100);
    state_is(M_WAKE, 1'b0, 1'b0);
    hot = 1'b0;
    cyc(5);
    state_is(M_WAKE, 1'b0, 1'b1);
    cyc(60);
    state_is(M_ACT, 1'b1, 1'b1);
  endtask

  task automatic t_late_wake();
    bus_dom = 1'b1;
    cyc(3);
    `CHK("rxd", 1'b0, rxd)
    host.ask_standby();
    cyc(1000);
    state_is(M_WAKE, 1'b1, 1'b1);
    `CHK("rxd", 1'b1, rxd)
    cyc(700);
    `CHK("rxd", 1'b0, rxd)
    bus_dom = 1'b0;
  endtask

  task automatic t_shutdown();
    @(negedge clk);
    sup_lo = 1'b0;
    sup_hi = 1'b0;
    #1;
    state_is(M_OFF, 1'b0, 1'b0);
    `CHK("rxd", 1'b1, rxd)
    cyc(2);
    sup_lo = 1'b1;
    hot    = 1'b1;
    cyc(20);
    state_is(M_OFF, 1'b0, 1'b0);
    sup_hi = 1'b1;
    cyc(20);
    state_is(M_OFF, 1'b0, 1'b0);
    hot = 1'b0;
    cyc(10);
    state_is(M_WAKE, 1'b0, 1'b1);
  endtask

  // ****************************************************************
  // sequence and watchdog
  // ****************************************************************
  initial begin
    rst_n           = 1'b0;
    sup_lo          = 1'b1;
    sup_hi          = 1'b1;
    uv              = 1'b0;
    hot             = 1'b0;
    dto             = 1'b0;
    bus_dom         = 1'b0;
    fail_count      = 0;
    samples_checked = 0;
    repeat (12) @(negedge clk);
    t_startup();
    t_normal();
    t_transmit();
    t_sleep();
    t_wake();
    t_undervoltage();
    t_thermal();
    t_late_wake();
    t_shutdown();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule
